// ---- verilog/mbcw_pkg.sv ----
package mbcw_pkg;

   // ==========================================================
   // Field widths
   localparam int LIM_W   = 6;
   localparam int IVAL_W  = 8;
   localparam int UNIT_W  = 5;
   localparam int NBIT_W  = 4;
   localparam int PRESC_W = 8;

   // ==========================================================
   // Base tick: oscillator periods per tick for each variant
   localparam logic [PRESC_W-1:0] TICK_OSC_315 = 8'h1E;
   localparam logic [PRESC_W-1:0] TICK_OSC_STD = 8'h1C;

   // Band 0 scales by 8 (shift 3), band 3 by 1 (shift 0)
   localparam logic [1:0]        BAND_SHIFT_MAX = 2'h3;

   // ==========================================================
   // Counter and data constants
   localparam logic [IVAL_W-1:0] IVAL_ZERO   = 8'h00;
   localparam logic [IVAL_W-1:0] IVAL_SAT    = 8'hFF;
   localparam logic [IVAL_W-1:0] IVAL_ONE    = 8'h01;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 8'h00;
   localparam logic [PRESC_W-1:0] PRESC_ONE  = 8'h01;
   localparam logic [UNIT_W-1:0] UNIT_ZERO   = 5'h00;
   localparam logic [UNIT_W-1:0] UNIT_HALF   = 5'h01;
   localparam logic [UNIT_W-1:0] UNIT_FULL   = 5'h02;
   localparam logic              DATA_IDLE   = 1'b1;

   // ==========================================================
   // Receive FIFO shape
   localparam int FIFO_DEPTH = 8;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_CHECK = 2'b01,
      ST_RECV  = 2'b10
   } mbcw_state_t;

   typedef struct packed {
      logic [LIM_W-1:0] lower;
      logic [LIM_W-1:0] upper;
   } mbcw_limits_t;

   typedef struct packed {
      logic              level;
      logic [IVAL_W-1:0] ticks;
   } mbcw_edge_t;

   localparam int EDGE_W = $bits(mbcw_edge_t);

endpackage

// ---- verilog/mbcw_fifo.sv ----
module mbcw_fifo
   import mbcw_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  logic             clk_i,
   input  logic             rst_n_i,
   // Fill side
   input  logic             in_valid_i,
   output logic             in_ready_o,
   input  logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic             out_valid_o,
   input  logic             out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      fill_r;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill_r != (AW+1)'(DEPTH));
   assign out_valid_o = (fill_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // ==========================================================
   // Storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // ==========================================================
   // Pointers and fill level
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r   <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
         end
         if (push && !pop) begin
            fill_r <= fill_r + (AW+1)'(1);
         end else if (pop && !push) begin
            fill_r <= fill_r - (AW+1)'(1);
         end
      end
   end

endmodule

// ---- verilog/mbcw_bit_check.sv ----
// What this block does
// RQ1: Sender uses Manchester code for the telegram.
// RQ2: Telegram order: preburst, start bit, data.
// RQ3: Preburst is a run of identical bits.
// RQ4: Start bit flips away from preburst value.
// RQ5: Preburst covers sleep, startups and bit check.
// RQ6: Three-bit check finishes within about 3.5 bits.
// RQ7: Measure time between demodulator output edges.
// RQ8: Accept interval only inside programmed window.
// RQ9: Window bounds come from host-programmed counts.
// RQ10: Lower bound L ticks, upper (U-1) ticks.
// RQ11: Scaled tick is base times 8/4/2/1.
// RQ12: Base tick is 30 or 28 oscillator periods.
// RQ13: Full-bit bounds derived internally from half counts.
// RQ14: Full bounds are S minus/plus half D.
// RQ15: Each counted bit equals two half intervals.
// RQ16: Enough passes: enter receive, drive data out.
// RQ17: Any bad interval: stop check, go sleep.
// RQ18: Host picks half window near 25-30 percent.
// RQ19: Then full window is about 12.5 percent.
// RQ20: Tick counter restarts each edge, compared there.
// RQ21: Half window, full window, else reject.
module mbcw_bit_check
   import mbcw_pkg::*;
(
   // Clock and reset
   input  logic              clk_i,
   input  logic              rst_n_i,
   // Demodulator output
   input  logic              demod_i,
   // Configuration
   input  mbcw_limits_t      limits_i,
   input  logic [1:0]        rate_band_i,
   input  logic              variant_315_i,
   input  logic [NBIT_W-1:0] required_bit_pass_count_i,
   // Control
   input  logic              check_start_i,
   input  logic              rx_stop_i,
   // Status
   output logic              active_o,
   output logic              checking_o,
   output logic              receiving_o,
   output logic              check_pass_o,
   output logic              check_fail_o,
   output logic              overflow_o,
   // Received data
   output logic              data_o,
   output logic              rx_valid_o,
   input  logic              rx_ready_i,
   output mbcw_edge_t        rx_edge_o
);

   // ==========================================================
   // Declarations
   mbcw_state_t        state_r;
   mbcw_state_t        state_nxt;
   logic               demod_prev_r;
   logic               edge_seen;
   logic [PRESC_W-1:0] tick_len;
   logic [PRESC_W-1:0] presc_r;
   logic               tick;
   logic [IVAL_W-1:0]  ival_r;
   logic               armed_r;
   logic [UNIT_W-1:0]  units_r;
   logic [UNIT_W-1:0]  units_sum;
   logic [UNIT_W-1:0]  units_goal;
   logic [IVAL_W-1:0]  half_floor;
   logic [IVAL_W-1:0]  half_ceiling;
   logic [IVAL_W-1:0]  full_sum;
   logic [IVAL_W-1:0]  full_diff;
   logic [IVAL_W-1:0]  full_bit_floor_count;
   logic [IVAL_W-1:0]  full_bit_ceiling_count;
   logic [IVAL_W-1:0]  late_limit;
   logic               half_ok;
   logic               full_ok;
   logic               measure;
   logic               pass_now;
   logic               fail_now;
   logic               fifo_in_ready;
   logic               fifo_out_valid;
   logic               fifo_out_ready;
   mbcw_edge_t         fifo_out_data;
   mbcw_edge_t         push_edge;
   logic               push_valid;
   logic               active_r;
   logic               checking_r;
   logic               receiving_r;
   logic               pass_r;
   logic               fail_r;
   logic               overflow_r;
   logic               data_r;
   logic               rx_valid_r;
   mbcw_edge_t         rx_edge_r;

   // ==========================================================
   // Edge detect and scaled tick
   assign edge_seen = (demod_i != demod_prev_r); // RQ7

   // Base tick in oscillator periods, shifted up for slow bands
   assign tick_len = (variant_315_i ? TICK_OSC_315 : TICK_OSC_STD) // RQ12
                     << (BAND_SHIFT_MAX - rate_band_i); // RQ11
   assign tick     = (presc_r == tick_len - PRESC_ONE);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         demod_prev_r <= DATA_IDLE;
      end else begin
         demod_prev_r <= demod_i;
      end
   end

   // Prescaler and interval counter both restart on an edge, so the
   // captured tick count is whole ticks since the last edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         presc_r <= PRESC_ZERO;
      end else if (edge_seen || tick) begin // RQ20
         presc_r <= PRESC_ZERO;
      end else begin
         presc_r <= presc_r + PRESC_ONE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ival_r <= IVAL_ZERO;
      end else if (edge_seen) begin // RQ20
         ival_r <= IVAL_ZERO;
      end else if (tick && ival_r != IVAL_SAT) begin
         ival_r <= ival_r + IVAL_ONE;
      end
   end

   // ==========================================================
   // Windows
   assign half_floor   = IVAL_W'(limits_i.lower); // RQ9
   assign half_ceiling = IVAL_W'(limits_i.upper) - IVAL_ONE; // RQ10
   assign full_sum     = IVAL_W'(limits_i.lower) + IVAL_W'(limits_i.upper);
   assign full_diff    = IVAL_W'(limits_i.upper) - IVAL_W'(limits_i.lower);
   assign full_bit_floor_count   = full_sum - (full_diff >> 1); // RQ13 RQ14
   assign full_bit_ceiling_count = full_sum + (full_diff >> 1); // RQ14

   assign half_ok = (ival_r >= half_floor) && (ival_r <= half_ceiling); // RQ8
   assign full_ok = (ival_r >= full_bit_floor_count)
                    && (ival_r <= full_bit_ceiling_count); // RQ21

   // Beyond both windows no later edge can pass, so fail without waiting;
   // this keeps the whole check within its bit-time budget
   assign late_limit = (full_bit_ceiling_count > half_ceiling) ? full_bit_ceiling_count : half_ceiling;

   assign measure    = (state_r == ST_CHECK) && armed_r && edge_seen;
   assign units_goal = UNIT_W'({required_bit_pass_count_i, 1'b0}); // RQ15
   assign units_sum  = units_r + (half_ok ? UNIT_HALF : UNIT_FULL); // RQ15

   always_comb begin
      pass_now = 1'b0;
      fail_now = 1'b0;
      if (measure) begin
         if (half_ok || full_ok) begin // RQ21
            pass_now = (units_sum >= units_goal);
         end else begin
            fail_now = 1'b1; // RQ17
         end
      end else if (state_r == ST_CHECK && armed_r && ival_r > late_limit) begin
         fail_now = 1'b1; // RQ6 RQ17
      end
   end

   // ==========================================================
   // Mode sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_SLEEP: begin
            if (check_start_i) begin
               state_nxt = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (fail_now) begin
               state_nxt = ST_SLEEP; // RQ17
            end else if (pass_now) begin
               state_nxt = ST_RECV; // RQ16
            end
         end
         ST_RECV: begin
            if (rx_stop_i) begin
               state_nxt = ST_SLEEP;
            end
         end
         default: begin
            state_nxt = ST_SLEEP;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_r <= ST_SLEEP;
      end else begin
         state_r <= state_nxt;
      end
   end

   // First edge in a check only opens the first interval
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         armed_r <= 1'b0;
      end else if (state_r != ST_CHECK) begin
         armed_r <= 1'b0;
      end else if (edge_seen) begin
         armed_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         units_r <= UNIT_ZERO;
      end else if (state_r != ST_CHECK) begin
         units_r <= UNIT_ZERO;
      end else if (measure && (half_ok || full_ok)) begin
         units_r <= units_sum; // RQ15
      end
   end

   // ==========================================================
   // Status and data pin
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         active_r    <= 1'b0;
         checking_r  <= 1'b0;
         receiving_r <= 1'b0;
         pass_r      <= 1'b0;
         fail_r      <= 1'b0;
      end else begin
         active_r    <= (state_nxt != ST_SLEEP);
         checking_r  <= (state_nxt == ST_CHECK);
         receiving_r <= (state_nxt == ST_RECV);
         pass_r      <= pass_now && !fail_now;
         fail_r      <= fail_now;
      end
   end

   // Pin idles high outside receive so the host sees no stray edges
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_r <= DATA_IDLE;
      end else if (state_r == ST_RECV) begin
         data_r <= demod_i; // RQ16
      end else begin
         data_r <= DATA_IDLE;
      end
   end

   // ==========================================================
   // Receive edge stream into the FIFO
   assign push_valid      = (state_r == ST_RECV) && edge_seen;
   assign push_edge.level = demod_i;
   assign push_edge.ticks = ival_r;

   // The pin cannot be stalled; a refused push is flagged. A new start
   // clears the flag, but a refusal in that same cycle still sets it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         overflow_r <= 1'b0;
      end else if (push_valid && !fifo_in_ready) begin
         overflow_r <= 1'b1;
      end else if (state_r == ST_SLEEP && check_start_i) begin
         overflow_r <= 1'b0;
      end
   end

   mbcw_fifo #(
      .WIDTH (EDGE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (push_edge),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   // Output register keeps the host port straight from flip-flops
   assign fifo_out_ready = !rx_valid_r || rx_ready_i;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rx_valid_r <= 1'b0;
         rx_edge_r  <= '0;
      end else if (fifo_out_ready) begin
         rx_valid_r <= fifo_out_valid;
         if (fifo_out_valid) begin
            rx_edge_r <= fifo_out_data;
         end
      end
   end

   assign active_o     = active_r;
   assign checking_o   = checking_r;
   assign receiving_o  = receiving_r;
   assign check_pass_o = pass_r;
   assign check_fail_o = fail_r;
   assign overflow_o   = overflow_r;
   assign data_o       = data_r;
   assign rx_valid_o   = rx_valid_r;
   assign rx_edge_o    = rx_edge_r;

   // ==========================================================
   // Checks
   property p_fail_to_sleep;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r == ST_CHECK && armed_r && edge_seen && !half_ok && !full_ok)
         |=> (state_r == ST_SLEEP) && check_fail_o;
   endproperty
   a_fail_to_sleep: assert property (p_fail_to_sleep) else $error("bad interval did not end check"); // RQ17

   property p_pass_to_recv;
      @(posedge clk_i) disable iff (!rst_n_i)
      (measure && (half_ok || full_ok) && units_sum >= units_goal)
         |=> receiving_o ##1 (data_o == $past(demod_i));
   endproperty
   a_pass_to_recv: assert property (p_pass_to_recv) else $error("passed check did not enter receive"); // RQ16

   property p_half_window;
      @(posedge clk_i) disable iff (!rst_n_i)
      measure && ival_r == IVAL_W'(limits_i.upper) && ival_r < full_bit_floor_count |=> check_fail_o;
   endproperty
   a_half_window: assert property (p_half_window) else $error("interval at U ticks accepted"); // RQ10

   property p_full_bounds;
      @(posedge clk_i) disable iff (!rst_n_i)
      (limits_i.upper >= limits_i.lower) |->
         (IVAL_W'(2) * full_bit_floor_count + IVAL_W'(limits_i.upper) - IVAL_W'(limits_i.lower) ==
          IVAL_W'(2) * (IVAL_W'(limits_i.lower) + IVAL_W'(limits_i.upper)) + (limits_i.upper[0] ^ limits_i.lower[0]));
   endproperty
   a_full_bounds: assert property (p_full_bounds) else $error("full-bit floor mismatch"); // RQ14

   property p_counter_restart;
      @(posedge clk_i) disable iff (!rst_n_i)
      edge_seen |=> (ival_r == IVAL_ZERO) && (presc_r == PRESC_ZERO);
   endproperty
   a_counter_restart: assert property (p_counter_restart) else $error("counter did not restart on edge"); // RQ20

   property p_tick_scale;
      @(posedge clk_i) disable iff (!rst_n_i)
      tick |-> (presc_r + PRESC_ONE) == (variant_315_i ? TICK_OSC_315 : TICK_OSC_STD) * (8'h08 >> rate_band_i);
   endproperty
   a_tick_scale: assert property (p_tick_scale) else $error("tick length wrong for band"); // RQ11

   property p_too_late;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r == ST_CHECK && armed_r && !edge_seen && ival_r > late_limit) |=> state_r == ST_SLEEP;
   endproperty
   a_too_late: assert property (p_too_late) else $error("overlong interval not rejected"); // RQ6

   property p_idle_pin;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_r != ST_RECV) |=> data_o == DATA_IDLE;
   endproperty
   a_idle_pin: assert property (p_idle_pin) else $error("data pin toggled outside receive"); // RQ16

   property p_no_early_pass;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(receiving_o) |-> $past(units_r) + UNIT_FULL >= units_goal;
   endproperty
   a_no_early_pass: assert property (p_no_early_pass) else $error("receive entered before enough bits"); // RQ15

   property p_overflow;
      @(posedge clk_i) disable iff (!rst_n_i)
      (push_valid && !fifo_in_ready) |=> overflow_o;
   endproperty
   a_overflow: assert property (p_overflow) else $error("refused push not flagged");

endmodule

// ---- test/mbcw_tx_model.sv ----
module mbcw_tx_model (
   // Clock
   input  wire logic clk_i,
   // Demodulated line seen by the receiver
   output logic      demod_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Line level
   initial demod_o = 1'b0;

   task automatic level_for(input logic v, input int clks);
      demod_o <= v;
      repeat (clks) @(posedge clk_i);
   endtask

   // ==========================================================
   // Telegram
   // Ones as preburst, a zero start bit, then zeros as data. The line idles low so the
   // first rise of a frame is always an edge; full replaces the merged low of the start.
   task automatic send(input int pre, input int half, input int full, input int ndata);
      @(posedge clk_i);
      for (int i = 0; i < pre; i++) begin
         level_for(1'b1, half);
         level_for(1'b0, (i == pre - 1) ? ((full == 0) ? 2 * half : full) : half);
      end
      level_for(1'b1, half);
      for (int j = 0; j < ndata; j++) begin
         level_for(1'b0, half);
         level_for(1'b1, half);
      end
      level_for(1'b0, half);
   endtask
endmodule

// ---- test/tb.sv ----
module tb;
   import mbcw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Signals
   typedef struct {
      int band;
      int v315;
      int n;
      int pre;
      int half;
      int full;
      int ndata;
      bit ok;
   } mbcw_row_t;

   logic              clk_i    = 1'b0;
   logic              rst_n_i  = 1'b0;
   logic              demod;
   mbcw_limits_t      limits   = '{lower: 6'h08, upper: 6'h0D};
   logic [1:0]        band     = 2'h3;
   logic              v315     = 1'b0;
   logic [NBIT_W-1:0] req_n    = 4'h3;
   logic              start    = 1'b0;
   logic              stop     = 1'b0;
   logic              rx_ready = 1'b1;
   logic              active, checking, receiving, pass_p, fail_p, ovf, data, rx_valid;
   mbcw_edge_t        rx_edge;
   int                errors      = 0;
   int                checks_done = 0;
   int                took;
   int                cnt;
   logic              lvl;
   logic              chk_on = 1'b0;
   logic              rcv_q  = 1'b0;
   logic              dm_q   = 1'b0;
   mbcw_row_t         rows [15];

   always #4 clk_i = ~clk_i;

   mbcw_tx_model u_mbcw_tx_model (.clk_i(clk_i), .demod_o(demod));

   mbcw_bit_check u_mbcw_bit_check (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .demod_i(demod), .limits_i(limits), .rate_band_i(band),
      .variant_315_i(v315), .required_bit_pass_count_i(req_n), .check_start_i(start),
      .rx_stop_i(stop), .active_o(active), .checking_o(checking), .receiving_o(receiving),
      .check_pass_o(pass_p), .check_fail_o(fail_p), .overflow_o(ovf), .data_o(data),
      .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_edge_o(rx_edge));

   // ==========================================================
   // Reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Data pin mirrors the line one cycle late only once receive has settled
   always @(posedge clk_i) begin
      if (chk_on && rcv_q && receiving) check(data, dm_q, "data pin follows");
      else if (chk_on && !rcv_q && !receiving) check(data, DATA_IDLE, "data pin idle");
      rcv_q <= receiving;
      dm_q  <= demod;
   end

   // ==========================================================
   // Bit check runs
   task automatic wait_outcome(input int limit);
      for (took = 0; took < limit; took++) begin
         @(posedge clk_i);
         #1;
         if (pass_p === 1'b1 || fail_p === 1'b1) break;
      end
      if (took == limit) begin
         check(1'b0, 1'b1, "outcome wait");
         print_verdict();
      end
   endtask

   task automatic run_row(input mbcw_row_t r, input bit stall);
      @(posedge clk_i);
      band     <= r.band[1:0];
      v315     <= r.v315[0];
      req_n    <= r.n[NBIT_W-1:0];
      rx_ready <= ~stall;
      start    <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      #1;
      check(checking, 1'b1, "check mode entered");
      fork
         u_mbcw_tx_model.send(r.pre, r.half, r.full, r.ndata);
         begin
            wait_outcome(30000);
            check(pass_p, r.ok, "bit check outcome");
            check(fail_p, !r.ok, "bit check fail pulse");
            if (r.ok) begin
               check(receiving, 1'b1, "receive mode");
               check(checking, 1'b0, "check mode left");
               if (r.pre == 4) check(took <= 7 * r.half, 1'b1, "check duration");
            end else begin
               check(active, 1'b0, "back to sleep");
            end
            @(posedge clk_i);
            #1;
            check(pass_p | fail_p, 1'b0, "outcome pulse ends");
         end
      join
      if (r.ok) begin
         @(posedge clk_i);
         stop <= 1'b1;
         @(posedge clk_i);
         stop <= 1'b0;
         @(posedge clk_i);
         #1;
         check(active, 1'b0, "receive stopped");
      end
      repeat (20) @(posedge clk_i);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rows = '{'{3, 0, 3, 4, 280, 0, 6, 1}, '{2, 0, 3, 4, 560, 0, 0, 1}, '{1, 0, 3, 4, 1120, 0, 0, 1},
               '{0, 0, 3, 4, 2240, 0, 0, 1}, '{3, 1, 3, 4, 300, 0, 0, 1}, '{3, 1, 3, 4, 230, 0, 0, 0},
               '{3, 0, 3, 4, 230, 0, 0, 1}, '{3, 0, 3, 4, 200, 0, 0, 0}, '{3, 0, 3, 4, 350, 0, 0, 1},
               '{3, 0, 3, 4, 378, 0, 0, 0}, '{3, 0, 3, 2, 280, 0, 0, 1}, '{3, 0, 4, 2, 280, 0, 0, 0},
               '{3, 0, 3, 2, 280, 504, 0, 0}, '{3, 0, 3, 2, 280, 686, 0, 0}, '{3, 0, 3, 2, 280, 616, 0, 1}};
      repeat (3) @(posedge clk_i);
      #1;
      check(active, 1'b0, "reset active");
      check(data, DATA_IDLE, "reset data pin");
      check(rx_valid, 1'b0, "reset record valid");
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk_on = 1'b1;
      $display("test reset done");
      foreach (rows[i]) begin
         run_row(rows[i], 1'b0);
         $display("test row %0d done", i);
      end
      // Host stalls while the line keeps toggling: the buffer must refuse, then drain whole
      run_row(rows[0], 1'b1);
      check(ovf, 1'b1, "overflow on full buffer");
      @(posedge clk_i);
      rx_ready <= 1'b1;
      cnt = 0;
      // Each record is looked at in the cycle before the edge that takes it
      repeat (60) begin
         #1;
         if (rx_valid === 1'b1) begin
            if (cnt > 0) check(rx_edge.level ^ lvl, 1'b1, "record level alternates");
            // 280-clock intervals are 9 whole ticks of 28 clocks; the stretched low is 19
            check(rx_edge.ticks, (cnt == 1) ? 8'h13 : 8'h09, "record ticks");
            lvl = rx_edge.level;
            cnt++;
         end
         @(posedge clk_i);
      end
      check(cnt, FIFO_DEPTH + 1, "records drained");
      check(rx_valid, 1'b0, "buffer empty");
      $display("test buffer done");
      // Reset in mid check
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      #1;
      check(ovf, 1'b0, "overflow cleared by new check");
      fork
         u_mbcw_tx_model.send(4, 280, 0, 0);
         begin
            repeat (600) @(posedge clk_i);
            rst_n_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            #1;
            check(active, 1'b0, "mid reset active");
            check(checking, 1'b0, "mid reset check mode");
            check(rx_valid, 1'b0, "mid reset record valid");
            @(posedge clk_i);
            rst_n_i <= 1'b1;
         end
      join
      repeat (20) @(posedge clk_i);
      $display("test mid reset done");
      print_verdict();
   end
endmodule
